// *** bench/apt_partner.sv ***
`timescale 1ns/10ps
module apt_partner (
    input wire logic aclk,
    output logic enc_a,
    output logic enc_b,
    output logic brk_in,
    output logic trig_in,
    output logic [3:0] ch_in
);
    initial begin
        {enc_a, enc_b, brk_in, trig_in, ch_in} = '0;
    end
    // quadrature steps, spaced for the input synchronisers
    task automatic enc(input logic fwd, input int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            if ((enc_a == enc_b) == fwd) enc_a <= !enc_a;
            else enc_b <= !enc_b;
        end
    endtask : enc
    task automatic brk(input logic v);
        brk_in <= v;
        @(posedge aclk);
    endtask : brk
    task automatic trig();
        trig_in <= 1'b1;
        repeat (4) @(posedge aclk);
        trig_in <= 1'b0;
    endtask : trig
    task automatic cap(input int c);
        ch_in[c] <= 1'b1;
        repeat (4) @(posedge aclk);
        ch_in[c] <= 1'b0;
    endtask : cap
endmodule : apt_partner

// *** bench/apt_timer_assertions.sv ***
`timescale 1ns/10ps
module apt_timer_assertions import apt_pkg::*; #(
    parameter int NCHAN = NCH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic brk_in,
    input wire logic [NCHAN-1:0] pwm_out,
    input wire logic [NCHAN-1:0] pwm_n_out,
    input wire logic trig_out,
    input wire logic [NDMA-1:0] dma_req
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence b_take;
        s_axi_bvalid && s_axi_bready;
    endsequence
    chk_wr_answer: assert property (wr_take |=> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    chk_rd_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    chk_b_done: assert property (b_take |=> !s_axi_bvalid)
        else $error("write response not released");
    chk_dma_update: assert property (dma_req[0] |-> trig_out)
        else $error("update dma request without update");
    chk_trig_pulse: assert property (trig_out |=> !trig_out)
        else $error("trigger out longer than one cycle");
    chk_break_idle: assert property (brk_in [*5] |=> $stable(pwm_out) && $stable(pwm_n_out))
        else $error("outputs move during break");
    chk_pair_overlap: assert property ((pwm_out & pwm_n_out) == '0)
        else $error("main and complement both on");
    chk_dma_chan: assert property (dma_req[4:1] != '0 |=> dma_req[4:1] == '0)
        else $error("channel dma request too long");
endmodule : apt_timer_assertions

bind apt_timer apt_timer_assertions #(.NCHAN(NCHAN)) i_apt_timer_assertions (.*);

// *** bench/apt_timer_test.sv ***
`timescale 1ns/10ps
module apt_timer_test import apt_pkg::*;;
    localparam logic [31:0] C_EN = 32'h1 << CTRL_EN;
    localparam logic [31:0] C_MOE = 32'h1 << OUT_MOE;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, dbg_halt, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic enc_a, enc_b, brk_in, trig_in, trig_out;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, ch_in, pwm_out, pwm_n_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [NDMA-1:0] dma_req;
    int fail_count = 0, checked = 0;
    apt_timer i_apt_timer (.*);
    apt_partner i_apt_partner (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error t=%0t value %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic cmpb(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error t=%0t flag %b want %b", $time, g, e);
        end
    endtask : cmpb
    task automatic results;
        $display("checked %0d, failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er = RESP_OKAY);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(ad && wd));
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        cmp(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask : waitc
    task automatic t_reset;
        rd(OFS_CTRL); cmp(d, 32'h0);
        rd(OFS_ARR); cmp(d, 32'h0000ffff);
        rd(OFS_OUTCFG); cmp(d, 32'h0);
        rd(8'h30); cmp(32'(r), 32'(RESP_SLVERR));
        wr(8'h32, 32'h1, RESP_SLVERR);
        $display("reset values done");
    endtask : t_reset
    task automatic t_count;
        logic [1:0] m [3] = '{CM_UP, CM_DOWN, CM_CENTER};
        int e [3] = '{15, 15, 12};
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_PSC, 32'h2);
            wr(OFS_ARR, 32'h4);
            wr(OFS_CNT, 32'h0);
            wr(OFS_CTRL, C_EN | (32'(m[i]) << CTRL_MODE) | (32'h1 << CTRL_DMA));
            n = 0;
            do @(posedge aclk); while (trig_out !== 1'b1);
            do begin
                @(posedge aclk);
                n++;
            end while (trig_out !== 1'b1);
            cmp(32'(n), 32'(e[i]));
            rd(OFS_STAT); cmpb(d[STAT_UPD], 1'b1);
        end
        $display("count modes done");
    endtask : t_count
    task automatic t_pwm;
        int c [3] = '{0, 2, 5};
        int hi, lo, ex, n;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PSC, 32'h0);
        wr(OFS_CHMODE, 32'(CH_PWM));
        wr(OFS_DT, 32'h0);
        wr(OFS_OUTCFG, C_MOE);
        wr(OFS_CTRL, C_EN);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CCR0, 32'(c[i]));
            waitc(12);
            hi = 0;
            lo = 0;
            repeat (20) begin
                @(posedge aclk);
                hi += int'(pwm_out[0] === 1'b1);
                lo += int'(pwm_n_out[0] === 1'b1);
            end
            ex = (c[i] > 4) ? 20 : c[i] * 4;
            cmp(32'(hi), 32'(ex));
            cmp(32'(lo), 32'(20 - ex));
        end
        wr(OFS_DT, 32'h3);
        wr(OFS_ARR, 32'h9);
        waitc(20);
        do @(posedge aclk); while (pwm_out[0] !== 1'b1);
        do @(posedge aclk); while (pwm_out[0] !== 1'b0);
        n = 0;
        while (pwm_n_out[0] !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        cmp(32'(n), 32'h3);
        $display("pwm done");
    endtask : t_pwm
    task automatic t_break;
        i_apt_partner.brk(1'b1);
        waitc(6);
        cmp(32'({pwm_out, pwm_n_out}), 32'h0);
        rd(OFS_STAT); cmpb(d[STAT_BRK], 1'b1);
        rd(OFS_OUTCFG); cmpb(d[OUT_MOE], 1'b0);
        i_apt_partner.brk(1'b0);
        $display("break done");
    endtask : t_break
    task automatic t_freeze;
        logic [31:0] a;
        wr(OFS_ARR, 32'h0000ffff);
        wr(OFS_CCR0, 32'h0000ffff);
        wr(OFS_OUTCFG, C_MOE);
        wr(OFS_CTRL, C_EN | (32'h1 << CTRL_FRZ));
        waitc(10);
        cmpb(pwm_out[0], 1'b1);
        dbg_halt <= 1'b1;
        waitc(6);
        rd(OFS_CNT);
        a = d;
        waitc(20);
        rd(OFS_CNT); cmp(d, a);
        cmpb(pwm_out[0], 1'b0);
        dbg_halt <= 1'b0;
        waitc(6);
        rd(OFS_CNT); cmpb(d != a, 1'b1);
        $display("freeze done");
    endtask : t_freeze
    task automatic t_enc;
        wr(OFS_CTRL, C_EN | (32'h1 << CTRL_ENC));
        wr(OFS_CNT, 32'd100);
        i_apt_partner.enc(1'b1, 8);
        waitc(6);
        rd(OFS_CNT); cmp(d, 32'd108);
        i_apt_partner.enc(1'b0, 8);
        waitc(6);
        rd(OFS_CNT); cmp(d, 32'd100);
        $display("encoder done");
    endtask : t_enc
    task automatic t_cap;
        logic seen;
        wr(OFS_CHMODE, 32'(CH_CAPTURE));
        wr(OFS_PSC, 32'h000000ff);
        wr(OFS_CTRL, C_EN | (32'h1 << CTRL_TRST) | (32'h1 << (CTRL_DMA + 2)));
        waitc(1000);
        i_apt_partner.trig();
        waitc(4);
        rd(OFS_CNT); cmpb(d < 32'h2, 1'b1);
        seen = 0;
        fork
            i_apt_partner.cap(1);
            repeat (12) begin
                @(posedge aclk);
                seen |= (dma_req[2] === 1'b1);
            end
        join
        cmpb(seen, 1'b1);
        rd(OFS_STAT); cmpb(d[STAT_CC + 1], 1'b1);
        rd(OFS_CCR0 + 8'h04); cmpb(d < 32'h3, 1'b1);
        $display("capture done");
    endtask : t_cap
    task automatic t_opm;
        logic seen;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CHMODE, 32'h7);
        wr(OFS_PSC, 32'h0);
        wr(OFS_ARR, 32'h9);
        wr(OFS_CCR0, 32'h5);
        wr(OFS_CNT, 32'h0);
        wr(OFS_CTRL, C_EN | (32'h1 << CTRL_OPM));
        seen = 0;
        repeat (30) begin
            @(posedge aclk);
            seen |= (pwm_out[0] === 1'b1);
        end
        cmpb(seen, 1'b1);
        cmpb(pwm_out[0], 1'b0);
        cmpb(pwm_out[1], 1'b1);
        rd(OFS_CTRL); cmpb(d[CTRL_EN], 1'b0);
        rd(OFS_CNT); cmp(d, 32'h0);
        $display("one-pulse done");
    endtask : t_opm
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, dbg_halt} = '0;
        {s_axi_awaddr, s_axi_araddr} = '0;
        // responses are always accepted
        {s_axi_bready, s_axi_rready} = 2'h3;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_count;
        t_pwm;
        t_break;
        t_freeze;
        t_enc;
        t_cap;
        t_opm;
        results;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        results;
    end
endmodule : apt_timer_test

// *** hdl/apt_deadtime.sv ***
`timescale 1ns/10ps
module apt_deadtime import apt_pkg::*; #(
    parameter int W = DT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_in,
    input wire logic [W-1:0] dt,
    output logic oc,
    output logic ocn
);
    apt_dt_e state_r;
    logic [W-1:0] cnt_r;
    logic side_r;

    // both sides off for dt cycles after each change of ref
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= DT_IDLE;
            cnt_r <= '0;
            side_r <= 1'b0;
            oc <= 1'b0;
            ocn <= 1'b0;
        end else begin
            case (state_r)
                DT_IDLE, DT_ON: begin
                    if (state_r == DT_IDLE || ref_in != side_r) begin
                        side_r <= ref_in;
                        cnt_r <= dt;
                        if (dt == '0) begin
                            oc <= ref_in;
                            ocn <= !ref_in;
                            state_r <= DT_ON;
                        end else begin
                            oc <= 1'b0;
                            ocn <= 1'b0;
                            state_r <= DT_WAIT;
                        end
                    end
                end
                DT_WAIT: begin
                    if (ref_in != side_r) begin
                        side_r <= ref_in;
                        cnt_r <= dt;
                    end else if ((cnt_r >> 1) == '0) begin
                        oc <= side_r;
                        ocn <= !side_r;
                        state_r <= DT_ON;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= DT_IDLE;
            endcase
        end
    end
endmodule : apt_deadtime

// *** hdl/apt_pkg.sv ***
package apt_pkg;
    localparam int CNT_W = 16;
    localparam int PSC_W = 16;
    localparam int NCH = 4;
    localparam int DT_W = 8;
    localparam int NDMA = 5;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PSC = 8'h04;
    localparam logic [7:0] OFS_ARR = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_CHMODE = 8'h14;
    localparam logic [7:0] OFS_DT = 8'h18;
    localparam logic [7:0] OFS_OUTCFG = 8'h1c;
    localparam logic [7:0] OFS_CCR0 = 8'h20;
    // ctrl fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_FRZ = 3;
    localparam int CTRL_ENC = 4;
    localparam int CTRL_OPM = 5;
    localparam int CTRL_TRST = 6;
    localparam int CTRL_DMA = 7;
    localparam int CTRL_W = 12;
    // status fields
    localparam int STAT_UPD = 0;
    localparam int STAT_CC = 1;
    localparam int STAT_BRK = 5;
    localparam int STAT_W = 6;
    // outcfg fields
    localparam int OUT_MOE = 8;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [15:0] ARR_RST = 16'hffff;
    localparam logic [8:0] OUTCFG_RST = 9'h000;
    // count modes, channel modes, response codes and dead-time states
    localparam logic [1:0] CM_UP = 2'h0;
    localparam logic [1:0] CM_DOWN = 2'h1;
    localparam logic [1:0] CM_CENTER = 2'h2;
    localparam logic [1:0] CH_CAPTURE = 2'h0;
    localparam logic [1:0] CH_COMPARE = 2'h1;
    localparam logic [1:0] CH_PWM = 2'h2;
    localparam logic [1:0] CH_ONEPULSE = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {DT_IDLE, DT_WAIT, DT_ON} apt_dt_e;
endpackage : apt_pkg

// *** hdl/apt_prescaler.sv ***
`timescale 1ns/10ps
module apt_prescaler import apt_pkg::*; #(
    parameter int W = PSC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [W-1:0] div_m1,
    output logic tick
);
    logic [W-1:0] cnt_r;

    // divide by div_m1 + 1
    always_ff @(posedge aclk) begin
        if (!aresetn || clear || !run) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r >= div_m1) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : apt_prescaler

// *** hdl/apt_timer.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Summary of operation
// - The counter clock is divided by the prescale value plus one.
// - A 16-bit counter counts up, down or up/down against reload.
// - Four channels each do capture, compare, pwm or one-pulse.
// - Pwm reference is high while count is below compare, 0 to 100%.
// - Each channel drives a complementary pair with dead-time.
// - Debug halt with freeze stops the counter and idles the outputs.
// - Trigger out is the update pulse, trigger in may reset the count.
// - Update and channel events raise enabled dma request pulses.
// - Encoder mode counts phase edges up or down by direction.
// - The update event is output as a converter and dma trigger.
module apt_timer import apt_pkg::*; #(
    parameter int NCHAN = NCH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCHAN-1:0] ch_in,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic brk_in,
    input wire logic trig_in,
    input wire logic dbg_halt,
    output logic [NCHAN-1:0] pwm_out,
    output logic [NCHAN-1:0] pwm_n_out,
    output logic trig_out,
    output logic [NDMA-1:0] dma_req
);
    localparam int NS = NCHAN + 5;

    logic [CTRL_W-1:0] ctrl_r;
    logic [PSC_W-1:0] psc_r;
    logic [CNT_W-1:0] arr_r;
    logic [CNT_W-1:0] cnt_r;
    logic dir_down_r;
    logic [STAT_W-1:0] stat_r;
    logic [2*NCHAN-1:0] chmode_r;
    logic [DT_W-1:0] dt_r;
    logic [8:0] outcfg_r;
    logic [CNT_W-1:0] ccr_r [NCHAN];
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    logic [NS-1:0] prev_r;
    logic [NCHAN-1:0] ref_r;
    logic [NCHAN-1:0] dt_oc;
    logic [NCHAN-1:0] dt_ocn;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic [31:0] wval;
    logic [1:0] cmode;
    logic run;
    logic tick;
    logic enc_step;
    logic enc_up;
    logic step;
    logic step_up;
    logic upd;
    logic trig_rise;
    logic frozen;
    logic brk_s;
    logic [NCHAN-1:0] cc_ev;

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a < OFS_CCR0 + 8'(4 * NCHAN));
    endfunction : mapped

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            OFS_CTRL: v = 32'(ctrl_r);
            OFS_PSC: v = 32'(psc_r);
            OFS_ARR: v = 32'(arr_r);
            OFS_CNT: v = 32'(cnt_r);
            OFS_STAT: v = 32'(stat_r);
            OFS_CHMODE: v = 32'(chmode_r);
            OFS_DT: v = 32'(dt_r);
            OFS_OUTCFG: v = 32'(outcfg_r);
            default: begin
                if (a >= OFS_CCR0 && mapped(a)) begin
                    v = 32'(ccr_r[2'(a[7:2] - OFS_CCR0[7:2])]);
                end
            end
        endcase
        return v;
    endfunction : reg_read

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v;
    endfunction : merge

    // two-stage synchronisers for pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= {dbg_halt, trig_in, brk_in, enc_b, enc_a, ch_in};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign brk_s = sync2_r[NCHAN+2];
    assign trig_rise = sync2_r[NCHAN+3] && !prev_r[NCHAN+3];
    assign frozen = ctrl_r[CTRL_FRZ] && sync2_r[NCHAN+4];
    assign run = ctrl_r[CTRL_EN] && !frozen;
    assign cmode = ctrl_r[CTRL_MODE +: 2];

    apt_prescaler #(.W(PSC_W)) u_psc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run && !ctrl_r[CTRL_ENC]),
        .clear(trig_rise && ctrl_r[CTRL_TRST]),
        .div_m1(psc_r),
        .tick(tick)
    );

    assign enc_step = run && ctrl_r[CTRL_ENC]
        && (sync2_r[NCHAN +: 2] != prev_r[NCHAN +: 2]);
    assign enc_up = sync2_r[NCHAN] ^ prev_r[NCHAN+1];

    always_comb begin
        step = ctrl_r[CTRL_ENC] ? enc_step : (tick && run);
        if (ctrl_r[CTRL_ENC]) begin
            step_up = enc_up;
        end else if (cmode == CM_CENTER) begin
            step_up = !dir_down_r;
        end else begin
            step_up = (cmode != CM_DOWN);
        end
        upd = step && (step_up ? (cnt_r >= arr_r) : (cnt_r == '0));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            dir_down_r <= 1'b0;
        end else if (trig_rise && ctrl_r[CTRL_TRST]) begin
            cnt_r <= '0;
            dir_down_r <= 1'b0;
        end else if (wr_go && awaddr_r == OFS_CNT) begin
            cnt_r <= wval[CNT_W-1:0];
        end else if (step) begin
            if (step_up) begin
                if (!upd) begin
                    cnt_r <= cnt_r + 1'b1;
                end else if (cmode == CM_CENTER && !ctrl_r[CTRL_ENC]) begin
                    cnt_r <= arr_r - 1'b1;
                    dir_down_r <= 1'b1;
                end else begin
                    cnt_r <= '0;
                end
            end else begin
                if (!upd) begin
                    cnt_r <= cnt_r - 1'b1;
                end else if (cmode == CM_CENTER && !ctrl_r[CTRL_ENC]) begin
                    cnt_r <= 16'h0001;
                    dir_down_r <= 1'b0;
                end else begin
                    cnt_r <= arr_r;
                end
            end
        end
    end

    // per-channel capture, compare, pwm and one-pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_r <= '0;
            for (int i = 0; i < NCHAN; i++) begin
                ccr_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCHAN; i++) begin
                case (chmode_r[2*i +: 2])
                    CH_CAPTURE: ref_r[i] <= 1'b0;
                    CH_COMPARE: begin
                        if (step && cnt_r == ccr_r[i]) begin
                            ref_r[i] <= !ref_r[i];
                        end
                    end
                    CH_PWM: ref_r[i] <= (cnt_r < ccr_r[i]);
                    CH_ONEPULSE: ref_r[i] <= run && (cnt_r >= ccr_r[i]);
                    default: ref_r[i] <= 1'b0;
                endcase
                if (wr_go && awaddr_r == OFS_CCR0 + 8'(4 * i)) begin
                    ccr_r[i] <= wval[CNT_W-1:0];
                end else if (chmode_r[2*i +: 2] == CH_CAPTURE
                        && sync2_r[i] && !prev_r[i]) begin
                    ccr_r[i] <= cnt_r;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCHAN; i++) begin
            if (chmode_r[2*i +: 2] == CH_CAPTURE) begin
                cc_ev[i] = sync2_r[i] && !prev_r[i];
            end else begin
                cc_ev[i] = step && (cnt_r == ccr_r[i]);
            end
        end
    end

    for (genvar g = 0; g < NCHAN; g++) begin : g_dt
        apt_deadtime #(.W(DT_W)) u_dt (
            .aclk(aclk),
            .aresetn(aresetn),
            .ref_in(ref_r[g]),
            .dt(dt_r),
            .oc(dt_oc[g]),
            .ocn(dt_ocn[g])
        );
    end

    // break or freeze forces idle levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= '0;
            pwm_n_out <= '0;
        end else if (brk_s || frozen || !outcfg_r[OUT_MOE]) begin
            pwm_out <= outcfg_r[NCHAN-1:0];
            pwm_n_out <= outcfg_r[2*NCHAN-1:NCHAN];
        end else begin
            pwm_out <= dt_oc;
            pwm_n_out <= dt_ocn;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_out <= 1'b0;
            dma_req <= '0;
        end else begin
            trig_out <= upd;
            dma_req <= {cc_ev, upd} & ctrl_r[CTRL_DMA +: NDMA];
        end
    end

    // register writes
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wval = merge(reg_read(awaddr_r), wdata_r, wstrb_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            psc_r <= '0;
            arr_r <= ARR_RST;
            chmode_r <= '0;
            dt_r <= '0;
        end else begin
            if (wr_go && awaddr_r == OFS_CTRL) begin
                ctrl_r <= wval[CTRL_W-1:0];
            end else if (upd && ctrl_r[CTRL_OPM]) begin
                ctrl_r[CTRL_EN] <= 1'b0;
            end
            if (wr_go && awaddr_r == OFS_PSC) begin
                psc_r <= wval[PSC_W-1:0];
            end
            if (wr_go && awaddr_r == OFS_ARR) begin
                arr_r <= wval[CNT_W-1:0];
            end
            if (wr_go && awaddr_r == OFS_CHMODE) begin
                chmode_r <= wval[2*NCHAN-1:0];
            end
            if (wr_go && awaddr_r == OFS_DT) begin
                dt_r <= wval[DT_W-1:0];
            end
        end
    end

    // break drops main output enable until software sets it again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            outcfg_r <= OUTCFG_RST;
        end else begin
            if (wr_go && awaddr_r == OFS_OUTCFG) begin
                outcfg_r <= wval[8:0];
            end
            if (brk_s) begin
                outcfg_r[OUT_MOE] <= 1'b0;
            end
        end
    end

    // sticky flags, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= '0;
        end else begin
            stat_r <= (wr_go && awaddr_r == OFS_STAT)
                ? (stat_r & ~wdata_r[STAT_W-1:0]) : stat_r;
            if (upd) begin
                stat_r[STAT_UPD] <= 1'b1;
            end
            for (int i = 0; i < NCHAN; i++) begin
                if (cc_ev[i]) begin
                    stat_r[STAT_CC+i] <= 1'b1;
                end
            end
            if (brk_s) begin
                stat_r[STAT_BRK] <= 1'b1;
            end
        end
    end

    // write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= reg_read(s_axi_araddr);
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : apt_timer
